// >>> flash_status_write_protect.sv
// Overview of operation
// [RULE_01] Busy flag sits in bit 0, high during program, erase or status write.
// [RULE_02] While busy, every instruction except status read is ignored.
// [RULE_03] Busy clears to 0 once the running operation finishes.
// [RULE_04] Write latch flag sits in bit 1, set by write enable.
// [RULE_05] Latch clears at power-up, write disable, program, erase and status write.
// [RULE_06] Protection level bits 4..2 change only by the status write instruction.
// [RULE_07] Protection level bits come up as 0: nothing protected.
// [RULE_08] Program and erase inside the protected region are refused.
// [RULE_09] Bottom bit 0 protects from the top, 1 from the bottom.
// [RULE_10] Bottom bit starts at 0; changing it needs the latch set first.
// [RULE_11] Lock bit 7 starts at 0; while 0 the guard pin does nothing.
// [RULE_12] Lock set and guard pin low: status writes are ignored.
// [RULE_13] Bit 6 always reads 0.
// [RULE_14] The host should mask bit 6 when testing status.
// [RULE_15] Largest part: code 1 guards 1/64, each step doubles, 7 guards all.
// [RULE_16] Smaller parts scale the same scheme; smallest starts at 1/32.
// [RULE_17] Instruction 06h framed alone sets the write latch.
// [RULE_18] Instruction 04h framed alone clears the write latch.
// [RULE_19] Write, program or erase frames ending off a byte boundary are aborted.
`timescale 1ns/1ns
`default_nettype none

module flash_status_write_protect #(
    parameter int ADDR_W = flash_protect_pkg::ARRAY_ADDR_W,
    parameter int FIRST_LOG2 = flash_protect_pkg::FIRST_PORTION_LOG2,
    parameter int T_STATUS = flash_protect_pkg::STATUS_WRITE_CYCLES,
    parameter int T_PROGRAM = flash_protect_pkg::PAGE_PROGRAM_CYCLES,
    parameter int T_SECTOR = flash_protect_pkg::SECTOR_ERASE_CYCLES,
    parameter int T_BLOCK = flash_protect_pkg::BLOCK_ERASE_CYCLES,
    parameter int T_CHIP = flash_protect_pkg::CHIP_ERASE_CYCLES
) (
    // Clock, reset and enable
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    // Serial pins
    input wire logic SPI_SCK,
    input wire logic SPI_CS_N,
    input wire logic SPI_DIO,
    output logic SPI_DO,
    output logic SPI_DO_OE,
    input wire logic WP_N,
    // Status and array operation start
    output flash_protect_pkg::status_t STATUS,
    output logic ARRAY_START,
    output flash_protect_pkg::array_req_t ARRAY_REQ
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------------
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic sck_prev_reg;
    logic cs_prev_reg;
    logic sck_rise;
    logic sck_fall;
    logic frame_start;
    logic frame_end;
    logic selected;
    logic dio_s;
    logic wp_n_s;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_meta_reg <= 4'h3;
            pin_sync_reg <= 4'h3;
            sck_prev_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else if (CE) begin
            pin_meta_reg <= {WP_N, SPI_DIO, SPI_CS_N, SPI_SCK};
            pin_sync_reg <= pin_meta_reg;
            sck_prev_reg <= pin_sync_reg[0];
            cs_prev_reg <= pin_sync_reg[1];
        end
    end

    assign selected = ~pin_sync_reg[1];
    assign dio_s = pin_sync_reg[2];
    assign wp_n_s = pin_sync_reg[3];
    assign sck_rise = CE & selected & pin_sync_reg[0] & ~sck_prev_reg;
    assign sck_fall = CE & selected & ~pin_sync_reg[0] & sck_prev_reg;
    assign frame_start = CE & ~pin_sync_reg[1] & cs_prev_reg;
    assign frame_end = CE & pin_sync_reg[1] & ~cs_prev_reg;

    // ------------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------------
    logic [11:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [7:0] data_reg;
    logic [23:0] addr_reg;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            bit_cnt_reg <= 12'h000;
            shift_reg <= 8'h00;
            opcode_reg <= 8'h00;
            data_reg <= 8'h00;
            addr_reg <= 24'h0000;
        end else if (frame_start) begin
            bit_cnt_reg <= 12'h000;
        end else if (sck_rise) begin
            shift_reg <= {shift_reg[6:0], dio_s};
            if (bit_cnt_reg != flash_protect_pkg::BITS_MAX) begin
                bit_cnt_reg <= bit_cnt_reg + 12'h001;
            end
            if (bit_cnt_reg == flash_protect_pkg::BITS_OPCODE - 12'h001) begin
                opcode_reg <= {shift_reg[6:0], dio_s};
            end
            if (bit_cnt_reg == flash_protect_pkg::BITS_STATUS_WRITE - 12'h001) begin
                data_reg <= {shift_reg[6:0], dio_s};
            end
            if (bit_cnt_reg >= flash_protect_pkg::BITS_OPCODE &&
                bit_cnt_reg < flash_protect_pkg::BITS_ADDRESS) begin
                addr_reg <= {addr_reg[22:0], dio_s};
            end
        end
    end

    // ------------------------------------------------------------------
    // Instruction decode at the end of a frame
    // ------------------------------------------------------------------
    logic busy_reg;
    logic latch_reg;
    logic [2:0] level_reg;
    logic bottom_reg;
    logic lock_reg;
    logic [31:0] busy_cnt_reg;
    logic on_byte;
    logic guarded;
    logic in_region;
    logic exec;
    logic do_latch_set;
    logic do_latch_clear;
    logic do_status;
    logic is_array;
    logic array_len_ok;
    logic do_array;
    logic array_refused;
    flash_protect_pkg::array_kind_t kind;
    logic [31:0] array_time;

    protect_range_decode #(
        .ADDR_W(ADDR_W),
        .FIRST_LOG2(FIRST_LOG2)
    ) u_range (
        .level(level_reg),
        .from_bottom(bottom_reg),
        .addr(addr_reg[ADDR_W-1:0]),
        .hit(in_region)
    );

    assign on_byte = bit_cnt_reg[2:0] == 3'h0; // RULE_19
    assign exec = frame_end & ~busy_reg & on_byte; // RULE_02 RULE_19
    assign guarded = lock_reg & ~wp_n_s; // RULE_11 RULE_12
    assign do_latch_set = exec & opcode_reg == flash_protect_pkg::OP_WRITE_ENABLE &
        bit_cnt_reg == flash_protect_pkg::BITS_OPCODE; // RULE_17
    assign do_latch_clear = exec & opcode_reg == flash_protect_pkg::OP_WRITE_DISABLE &
        bit_cnt_reg == flash_protect_pkg::BITS_OPCODE; // RULE_18
    assign do_status = exec & latch_reg & ~guarded &
        opcode_reg == flash_protect_pkg::OP_WRITE_STATUS &
        bit_cnt_reg == flash_protect_pkg::BITS_STATUS_WRITE; // RULE_10 RULE_12

    always_comb begin
        is_array = 1'b1;
        array_len_ok = bit_cnt_reg == flash_protect_pkg::BITS_ADDRESS;
        kind = flash_protect_pkg::KIND_SECTOR;
        array_time = 32'(T_SECTOR);
        case (opcode_reg)
            flash_protect_pkg::OP_PAGE_PROGRAM: begin
                kind = flash_protect_pkg::KIND_PROGRAM;
                array_time = 32'(T_PROGRAM);
                array_len_ok = bit_cnt_reg >= flash_protect_pkg::BITS_FIRST_DATA;
            end
            flash_protect_pkg::OP_SECTOR_ERASE: begin
                kind = flash_protect_pkg::KIND_SECTOR;
            end
            flash_protect_pkg::OP_BLOCK_ERASE: begin
                kind = flash_protect_pkg::KIND_BLOCK;
                array_time = 32'(T_BLOCK);
            end
            flash_protect_pkg::OP_CHIP_ERASE: begin
                kind = flash_protect_pkg::KIND_CHIP;
                array_time = 32'(T_CHIP);
                array_len_ok = bit_cnt_reg == flash_protect_pkg::BITS_OPCODE;
            end
            default: begin
                is_array = 1'b0;
            end
        endcase
    end

    // Chip erase touches every region, so any protection at all refuses it.
    assign array_refused = (kind == flash_protect_pkg::KIND_CHIP) ?
        (level_reg != flash_protect_pkg::FACTORY_LEVEL) : in_region; // RULE_08
    assign do_array = exec & latch_reg & is_array & array_len_ok & ~array_refused; // RULE_08

    // ------------------------------------------------------------------
    // Busy timer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= 32'h0000_0000;
        end else if (CE) begin
            if (do_status) begin
                busy_reg <= 1'b1; // RULE_01
                busy_cnt_reg <= 32'(T_STATUS);
            end else if (do_array) begin
                busy_reg <= 1'b1; // RULE_01
                busy_cnt_reg <= array_time;
            end else if (busy_reg) begin
                busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
                if (busy_cnt_reg <= 32'h0000_0001) begin
                    busy_reg <= 1'b0; // RULE_03
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ARRAY_START <= 1'b0;
            ARRAY_REQ <= '0;
        end else if (CE) begin
            ARRAY_START <= do_array;
            if (do_array) begin
                ARRAY_REQ <= '{kind: kind, addr: addr_reg};
            end
        end
    end

    // ------------------------------------------------------------------
    // Write latch
    // ------------------------------------------------------------------
    // A refused program or erase leaves the latch set so the host can retry
    // at another address without a fresh write enable.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            latch_reg <= 1'b0; // RULE_05
        end else if (CE) begin
            if (do_latch_set) begin
                latch_reg <= 1'b1; // RULE_04 RULE_17
            end else if (do_latch_clear || do_status || do_array) begin
                latch_reg <= 1'b0; // RULE_05 RULE_18
            end
        end
    end

    // ------------------------------------------------------------------
    // Protection bits
    // ------------------------------------------------------------------
    // No non-volatile store exists here; reset loads the factory values.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            level_reg <= flash_protect_pkg::FACTORY_LEVEL; // RULE_07
            bottom_reg <= flash_protect_pkg::FACTORY_BOTTOM; // RULE_10
            lock_reg <= flash_protect_pkg::FACTORY_LOCK; // RULE_11
        end else if (do_status) begin
            level_reg <= data_reg[flash_protect_pkg::LEVEL_LSB_POS +: 3]; // RULE_06
            bottom_reg <= data_reg[flash_protect_pkg::BOTTOM_POS];
            lock_reg <= data_reg[flash_protect_pkg::LOCK_POS];
        end
    end

    always_comb begin
        STATUS = '{status_lock: lock_reg, reserved: 1'b0, // RULE_13
            protect_from_bottom: bottom_reg, protect_level: level_reg,
            write_latch_flag: latch_reg, busy: busy_reg};
    end

    // ------------------------------------------------------------------
    // Status readout
    // ------------------------------------------------------------------
    logic reading;
    logic [2:0] out_idx_reg;
    logic [7:0] out_snap_reg;

    // Opcode and count still hold the last frame's values on the edge that opens a new one.
    assign reading = selected & ~frame_start & opcode_reg == flash_protect_pkg::OP_READ_STATUS &
        bit_cnt_reg >= flash_protect_pkg::BITS_OPCODE;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            out_idx_reg <= 3'h0;
            out_snap_reg <= 8'h00;
            SPI_DO <= 1'b0;
            SPI_DO_OE <= 1'b0;
        end else if (CE) begin
            SPI_DO_OE <= reading;
            if (frame_start) begin
                out_idx_reg <= 3'h0;
            end else if (sck_fall && reading) begin
                out_idx_reg <= out_idx_reg + 3'h1;
                if (out_idx_reg == 3'h0) begin
                    SPI_DO <= STATUS[7];
                    out_snap_reg <= STATUS;
                end else begin
                    SPI_DO <= out_snap_reg[3'h7 - out_idx_reg];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_status_accept;
        do_status && CE;
    endsequence

    sequence s_busy_hold;
        busy_reg [*2];
    endsequence

    a_status_busy: assert property (s_status_accept |=> s_busy_hold and !latch_reg) // RULE_01
        else $error("status write did not raise busy and drop the latch");
    a_busy_ignores: assert property (frame_end && busy_reg |=> $stable(latch_reg)) // RULE_02
        else $error("instruction acted on while busy");
    a_busy_ends: assert property (CE && busy_reg && busy_cnt_reg == 32'h0000_0001 |=> !busy_reg) // RULE_03
        else $error("busy did not clear at the end of the operation");
    a_latch_set: assert property (do_latch_set |=> latch_reg) // RULE_04
        else $error("write enable did not set the latch");
    a_latch_clear: assert property (do_latch_clear || (do_array && CE) |=> !latch_reg) // RULE_05
        else $error("latch not cleared");
    a_lock_holds: assert property (frame_end && guarded |=> $stable(level_reg) && $stable(bottom_reg)) // RULE_12
        else $error("status write went through while locked");
    a_reserved_zero: assert property (SPI_DO_OE && out_idx_reg == 3'h2 |-> !SPI_DO) // RULE_13
        else $error("reserved bit read as 1");
    a_refuse_region: assert property (ARRAY_START |-> !$past(array_refused)) // RULE_08
        else $error("write started inside a protected region");
    a_full_code: assert property (level_reg == 3'h7 && !busy_reg |-> in_region) // RULE_15
        else $error("code 7 did not protect everything");
    a_byte_abort: assert property (frame_end && !on_byte && !busy_reg |=> !busy_reg) // RULE_19
        else $error("frame off a byte boundary was executed");

endmodule

`default_nettype wire

// >>> protect_range_decode.sv
package flash_protect_pkg;

    // ------------------------------------------------------------------
    // Status bit positions and factory values
    // ------------------------------------------------------------------
    localparam int BUSY_POS = 0;
    localparam int LATCH_POS = 1;
    localparam int LEVEL_LSB_POS = 2;
    localparam int BOTTOM_POS = 5;
    localparam int RESERVED_POS = 6;
    localparam int LOCK_POS = 7;
    localparam logic [2:0] FACTORY_LEVEL = 3'h0;
    localparam logic FACTORY_BOTTOM = 1'b0;
    localparam logic FACTORY_LOCK = 1'b0;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;

    // ------------------------------------------------------------------
    // Frame bit counts
    // ------------------------------------------------------------------
    localparam logic [11:0] BITS_OPCODE = 12'h008;
    localparam logic [11:0] BITS_STATUS_WRITE = 12'h010;
    localparam logic [11:0] BITS_ADDRESS = 12'h020;
    localparam logic [11:0] BITS_FIRST_DATA = 12'h028;
    localparam logic [11:0] BITS_MAX = 12'hFFF;

    // ------------------------------------------------------------------
    // Operation times and their clock counts
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int STATUS_WRITE_TIME_US = 10000;
    localparam int PAGE_PROGRAM_TIME_US = 1000;
    localparam int SECTOR_ERASE_TIME_US = 100000;
    localparam int BLOCK_ERASE_TIME_US = 1000000;
    localparam int CHIP_ERASE_TIME_US = 10000000;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLK_MHZ;
    localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Density defaults of the largest variant
    // ------------------------------------------------------------------
    localparam int ARRAY_ADDR_W = 23;
    localparam int FIRST_PORTION_LOG2 = 6;

    typedef enum logic [1:0] {
        KIND_PROGRAM,
        KIND_SECTOR,
        KIND_BLOCK,
        KIND_CHIP
    } array_kind_t;

    typedef struct packed {
        array_kind_t kind;
        logic [23:0] addr;
    } array_req_t;

    typedef struct packed {
        logic status_lock;
        logic reserved;
        logic protect_from_bottom;
        logic [2:0] protect_level;
        logic write_latch_flag;
        logic busy;
    } status_t;

endpackage

`timescale 1ns/1ns
`default_nettype none

module protect_range_decode #(
    parameter int ADDR_W = flash_protect_pkg::ARRAY_ADDR_W,
    parameter int FIRST_LOG2 = flash_protect_pkg::FIRST_PORTION_LOG2
) (
    // Protection setting
    input wire logic [2:0] level,
    input wire logic from_bottom,
    // Target address
    input wire logic [ADDR_W-1:0] addr,
    output logic hit
);

    // A code n fixes the top (FIRST_LOG2 + 1 - n) address bits; the smallest
    // region sits at one end and each code step doubles it.
    always_comb begin
        int fixed;
        fixed = FIRST_LOG2 + 1 - int'(level);
        hit = 1'b1;
        if (level == 3'h0) begin
            hit = 1'b0;
        end else if (fixed <= 0) begin
            hit = 1'b1; // RULE_15 RULE_16
        end else begin
            for (int i = 0; i < ADDR_W; i++) begin
                if (i >= ADDR_W - fixed) begin
                    hit = hit & (addr[i] ^ from_bottom); // RULE_09 RULE_15 RULE_16
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sck,
    output logic cs_n,
    output logic dio,
    input wire logic do_line
);
    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    // The serial clock rests low between frames, as in mode 0.
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        dio = 1'b0;
    end

    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    // Half a serial clock period is four system clocks, giving 80 ns.
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // Shifts nbits from the top of data, MSB first, and keeps the last byte read back.
    task automatic xfer(input logic [39:0] data, input int nbits, output logic [7:0] rd);
        logic [7:0] sh;
        sh = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            dio = data[39-i];
            half();
            sck = 1'b1;
            half();
            // Sampling just before the fall keeps clear of the output's resync delay.
            sh = {sh[6:0], do_line};
            sck = 1'b0;
        end
        // The released data line must not keep showing the last bit.
        dio = ~dio;
        half();
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
        rd = sh;
    endtask
endmodule

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wp_n = 1'b1;
    logic ce = 1'b1;
    logic sck, cs_n, dio, spi_do, spi_do_oe, array_start;
    wire do_line = spi_do_oe ? spi_do : 1'bz;
    flash_protect_pkg::status_t status;
    flash_protect_pkg::array_req_t array_req, last_req;
    int n_mismatch = 0;
    int compares = 0;
    int starts = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic [23:0] size;

    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Device and host
    // ------------------------------------------------------------------
    // Short operation times keep the run small; busy is long enough to read during.
    flash_status_write_protect #(.T_STATUS(400), .T_PROGRAM(40), .T_SECTOR(40),
        .T_BLOCK(40), .T_CHIP(40)) uut (.CLK(clk), .RESET(reset), .CE(ce),
        .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_DIO(dio), .SPI_DO(spi_do),
        .SPI_DO_OE(spi_do_oe), .WP_N(wp_n), .STATUS(status),
        .ARRAY_START(array_start), .ARRAY_REQ(array_req));

    spi_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .dio(dio), .do_line(do_line));

    always @(posedge clk) begin
        cycles++;
        if (array_start === 1'b1) begin
            starts++;
            last_req = array_req;
        end
        if (cycles == 60000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic op(input logic [7:0] code);
        host.xfer({code, 32'h0000_0000}, 8, rd);
    endtask

    task automatic wsr(input logic [7:0] d);
        host.xfer({8'h01, d, 24'h00_0000}, 16, rd);
    endtask

    task automatic rdsr();
        host.xfer({8'h05, 32'h0000_0000}, 16, rd);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 1000 && status.busy !== 1'b0; i++) begin
            @(negedge clk);
        end
        check(status.busy, 0, "busy stuck");
    endtask

    task automatic set_prot(input logic [7:0] d);
        op(8'h06);
        wsr(d);
        wait_idle();
        check(status, d & 8'hBC, "status write");
    endtask

    task automatic attempt(input flash_protect_pkg::array_kind_t k, input logic [23:0] a,
        input bit ok);
        int s0;
        s0 = starts;
        op(8'h06);
        case (k)
            flash_protect_pkg::KIND_PROGRAM: host.xfer({8'h02, a, 8'hA5}, 40, rd);
            flash_protect_pkg::KIND_SECTOR: host.xfer({8'h20, a, 8'h00}, 32, rd);
            flash_protect_pkg::KIND_BLOCK: host.xfer({8'hD8, a, 8'h00}, 32, rd);
            default: op(8'hC7);
        endcase
        check(starts - s0, ok, "start count");
        if (ok) begin
            if (k == flash_protect_pkg::KIND_CHIP) begin
                check(last_req.kind, k, "chip kind");
            end else begin
                check(last_req, {k, a}, "request");
            end
            check(status[1:0], 2'b01, "busy and latch");
            wait_idle();
        end else begin
            check(status[1:0], 2'b10, "refused op");
            op(8'h04);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        check(status, 8'h00, "reset status");
        rdsr();
        check(rd, 8'h00, "read at reset");
        host.xfer({8'h06, 32'h0000_0000}, 7, rd);
        check(status, 8'h00, "short frame");
        // A whole frame sent while the clock enable is low must leave no trace.
        ce = 1'b0;
        op(8'h06);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        check(status, 8'h00, "frame while frozen");
        wsr(8'h1C);
        check(status, 8'h00, "write without latch");
        op(8'h06);
        check(status, 8'h02, "latch set");
        rdsr();
        check(rd, 8'h02, "read latch");
        op(8'h04);
        check(status, 8'h00, "latch clear");
        op(8'h06);
        wsr(8'h64);
        check(status, 8'h25, "write start");
        op(8'h06);
        check(status, 8'h25, "enable while busy");
        rdsr();
        check(rd, 8'h25, "read while busy");
        wait_idle();
        check(status, 8'h24, "write done");
        // With the lock clear the guard pin held low must not matter.
        wp_n = 1'b0;
        for (int b = 0; b < 2; b++) begin
            for (int lv = 1; lv < 8; lv++) begin
                set_prot({2'b00, b[0], lv[2:0], 2'b00});
                size = 24'h02_0000 << (lv - 1);
                if (lv == 7) begin
                    attempt(flash_protect_pkg::KIND_SECTOR, b ? 24'h7F_FFFF : 24'h00_0000, 0);
                end else if (b == 0) begin
                    attempt(flash_protect_pkg::KIND_SECTOR, 24'h80_0000 - size, 0);
                    attempt(flash_protect_pkg::KIND_PROGRAM, 24'h7F_FFFF - size, 1);
                end else begin
                    attempt(flash_protect_pkg::KIND_SECTOR, size - 1, 0);
                    attempt(flash_protect_pkg::KIND_BLOCK, size, 1);
                end
            end
        end
        attempt(flash_protect_pkg::KIND_CHIP, 24'h00_0000, 0);
        wp_n = 1'b1;
        set_prot(8'h80);
        @(negedge clk);
        wp_n = 1'b0;
        op(8'h06);
        wsr(8'h9C);
        check(status, 8'h82, "locked write");
        @(negedge clk);
        wp_n = 1'b1;
        wsr(8'h00);
        wait_idle();
        check(status, 8'h00, "unlocked write");
        attempt(flash_protect_pkg::KIND_CHIP, 24'h00_0000, 1);
        test_done();
    end
endmodule

`default_nettype wire
